// ---- verilog/gcsr_top.sv ----
// Global control and status registers behind an AXI4-Lite slave.
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module gcsr_top (
   // Clock and reset
   input  wire logic                             clk_sys_i,
   input  wire logic                             rst_i,
   // AXI4-Lite write address and data
   input  wire logic                             s_axi_awvalid_i,
   output logic                                  s_axi_awready_o,
   input  wire logic [gcsr_pkg::ADDR_W-1:0]      s_axi_awaddr_i,
   input  wire logic                             s_axi_wvalid_i,
   output logic                                  s_axi_wready_o,
   input  wire logic [31:0]                      s_axi_wdata_i,
   input  wire logic [3:0]                       s_axi_wstrb_i,
   // AXI4-Lite write response
   output logic                                  s_axi_bvalid_o,
   input  wire logic                             s_axi_bready_i,
   output logic [1:0]                            s_axi_bresp_o,
   // AXI4-Lite read
   input  wire logic                             s_axi_arvalid_i,
   output logic                                  s_axi_arready_o,
   input  wire logic [gcsr_pkg::ADDR_W-1:0]      s_axi_araddr_i,
   output logic                                  s_axi_rvalid_o,
   input  wire logic                             s_axi_rready_i,
   output logic [31:0]                           s_axi_rdata_o,
   output logic [1:0]                            s_axi_rresp_o,
   // Device sources
   input  wire gcsr_pkg::gcsr_src_t              src_pending_i,
   input  wire gcsr_pkg::gcsr_bufsel_t           buf_select_i,
   input  wire logic                             bus_req_i,
   // Device controls
   output logic                                  soft_reset_o,
   output logic                                  internal_dma_enable_o,
   output logic                                  osc_power_down_o,
   output logic                                  shaper_bypass_o,
   // Pins
   output gcsr_pkg::gcsr_pin_t                   irq_pin_o,
   output gcsr_pkg::gcsr_pin_t                   bus_request_out_o,
   input  wire logic [gcsr_pkg::PORT_N-1:0]      port_pin_i,
   output logic [gcsr_pkg::PORT_N-1:0]           port_pin_o,
   output logic [gcsr_pkg::PORT_N-1:0]           port_pin_oe_o
);

   gcsr_pkg::gcsr_state_t q;
   gcsr_pkg::gcsr_state_t d;
   logic [7:0]            gsum;
   logic [7:0]            dma_buffer_status;
   logic                  wr_fire;
   logic                  rd_fire;
   logic                  wr_soft;
   logic [5:0]            rd_idx;
   logic                  irq_active;

   function automatic logic is_mapped(input logic [5:0] idx);
      is_mapped = (idx == gcsr_pkg::IDX_CMD)   || (idx == gcsr_pkg::IDX_MODE)  ||
                  (idx == gcsr_pkg::IDX_DMA_BUFFER_STATUS)  || (idx == gcsr_pkg::IDX_GSTAT) ||
                  (idx == gcsr_pkg::IDX_DIR)   || (idx == gcsr_pkg::IDX_DAT)   ||
                  (idx == gcsr_pkg::IDX_ISTAT) || (idx == gcsr_pkg::IDX_IMASK);
   endfunction : is_mapped

   // Drives an active-low line either open drain or push-pull.
   function automatic gcsr_pkg::gcsr_pin_t drive_low(input logic act, input logic pp);
      drive_low.out = pp ? ~act : 1'b0;
      drive_low.oe  = pp | act;
   endfunction : drive_low

   // R11 R12 R13 summary mapping
   // R16 live summary
   // The summary is wired straight from the sources, so reading it never disturbs them.
   assign gsum = src_pending_i;

   // R10 buffer status view
   assign dma_buffer_status = q.mode[gcsr_pkg::MODE_DMA] ?
                 {buf_select_i.tx_b_buffer_select, 1'b0, buf_select_i.rx_b_buffer_select, 1'b0,
                  buf_select_i.tx_a_buffer_select, 1'b0, buf_select_i.rx_a_buffer_select, 1'b0}
                 : 8'h00;

   assign s_axi_awready_o = ~q.aw_got & ~q.bvalid;
   assign s_axi_wready_o  = ~q.w_got & ~q.bvalid;
   assign s_axi_arready_o = ~q.rvalid;
   assign s_axi_bvalid_o  = q.bvalid;
   assign s_axi_bresp_o   = q.bresp;
   assign s_axi_rvalid_o  = q.rvalid;
   assign s_axi_rdata_o   = {24'h000000, q.rdata};
   assign s_axi_rresp_o   = q.rresp;
   assign wr_fire         = q.aw_got & q.w_got;
   assign wr_soft         = wr_fire & q.w_en & (q.aw_idx == gcsr_pkg::IDX_CMD) &
                            q.w_data[gcsr_pkg::CMD_SOFT_RST];
   assign rd_fire         = s_axi_arvalid_i & ~q.rvalid;
   assign rd_idx          = s_axi_araddr_i[7:2];

   function automatic logic [7:0] rd_mux(input logic [5:0] idx, input gcsr_pkg::gcsr_state_t s,
                                         input logic [7:0] sum, input logic [7:0] buf_st);
      logic [7:0] v;
      v = 8'h00;
      unique case (idx)
         gcsr_pkg::IDX_MODE:  v = s.mode;
         gcsr_pkg::IDX_DMA_BUFFER_STATUS:  v = buf_st;
         gcsr_pkg::IDX_GSTAT: v = sum;
         // R14 upper direction bits read one
         gcsr_pkg::IDX_DIR:   v = {gcsr_pkg::DIR_RST[7:3], s.dir};
         // R15 pin level or driven level
         gcsr_pkg::IDX_DAT:   v = {5'h00, (s.dir & s.pin_s2) | (~s.dir & s.dat)};
         gcsr_pkg::IDX_ISTAT: v = s.irq_stat;
         gcsr_pkg::IDX_IMASK: v = s.irq_mask;
         default:             v = 8'h00;
      endcase
      rd_mux = v;
   endfunction : rd_mux

   always_comb begin
      d = q;
      // Address and data are taken independently, in either order.
      if (s_axi_awvalid_i && s_axi_awready_o) begin
         d.aw_got = 1'b1;
         d.aw_idx = s_axi_awaddr_i[7:2];
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
         d.w_got  = 1'b1;
         d.w_data = s_axi_wdata_i[7:0];
         d.w_en   = s_axi_wstrb_i[0];
      end
      if (q.bvalid && s_axi_bready_i) begin
         d.bvalid = 1'b0;
      end
      if (wr_fire) begin
         d.aw_got = 1'b0;
         d.w_got  = 1'b0;
         d.bvalid = 1'b1;
         d.bresp  = is_mapped(q.aw_idx) ? gcsr_pkg::RESP_OKAY : gcsr_pkg::RESP_SLVERR;
      end
      if (q.rvalid && s_axi_rready_i) begin
         d.rvalid = 1'b0;
      end
      if (rd_fire) begin
         d.rvalid = 1'b1;
         d.rdata  = rd_mux(rd_idx, q, gsum, dma_buffer_status);
         d.rresp  = is_mapped(rd_idx) ? gcsr_pkg::RESP_OKAY : gcsr_pkg::RESP_SLVERR;
      end
      d.pin_s1    = port_pin_i;
      d.pin_s2    = q.pin_s1;
      d.gsum_prev = gsum;
      // Read clears the sticky bits; a new event in the same cycle still lands.
      if (rd_fire && rd_idx == gcsr_pkg::IDX_ISTAT) begin
         d.irq_stat = 8'h00;
      end
      d.irq_stat = d.irq_stat | (gsum & ~q.gsum_prev);
      if (wr_fire && q.w_en) begin
         unique case (q.aw_idx)
            // R02 R04 R06 mode fields
            gcsr_pkg::IDX_MODE:  d.mode = {q.w_data[7], 1'b0, q.w_data[5:0]};
            gcsr_pkg::IDX_DIR:   d.dir = q.w_data[2:0];
            gcsr_pkg::IDX_DAT:   d.dat = q.w_data[2:0];
            gcsr_pkg::IDX_IMASK: d.irq_mask = q.w_data;
            default:             d.irq_mask = d.irq_mask;
         endcase
      end
      // R01 self clearing command
      d.soft_rst = wr_soft;
      // R01 full reset of fields
      // R07 mode reset value
      // The bus handshake is left alone so that an answer in flight still completes.
      if (q.soft_rst) begin
         d.mode      = gcsr_pkg::MODE_RST;
         d.dir       = gcsr_pkg::DIR_RST[2:0];
         d.dat       = gcsr_pkg::DAT_RST;
         d.irq_stat  = gcsr_pkg::ISTAT_RST;
         d.irq_mask  = gcsr_pkg::IMASK_RST;
         d.gsum_prev = 8'h00;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         q <= '{aw_got: 1'b0, aw_idx: 6'h00, w_got: 1'b0, w_data: 8'h00, w_en: 1'b0,
                bvalid: 1'b0, bresp: 2'h0, rvalid: 1'b0, rdata: 8'h00, rresp: 2'h0,
                soft_rst: 1'b0, mode: gcsr_pkg::MODE_RST, dir: gcsr_pkg::DIR_RST[2:0],
                dat: gcsr_pkg::DAT_RST, pin_s1: 3'h0, pin_s2: 3'h0, gsum_prev: 8'h00,
                irq_stat: gcsr_pkg::ISTAT_RST, irq_mask: gcsr_pkg::IMASK_RST};
      end else begin
         q <= d;
      end
   end

   // R08 global mask gate
   // R09 unmasked pending drives
   assign irq_active = ~q.mode[gcsr_pkg::MODE_GIM] & (|(q.irq_stat & ~q.irq_mask));

   // R03 interrupt pin style
   // The reserved code leaves the pin undriven rather than guess a polarity.
   always_comb begin
      unique case (q.mode[gcsr_pkg::MODE_IRQ_HI:gcsr_pkg::MODE_IRQ_LO])
         gcsr_pkg::IRQ_OD_LOW:  irq_pin_o = drive_low(irq_active, 1'b0);
         gcsr_pkg::IRQ_PP_LOW:  irq_pin_o = drive_low(irq_active, 1'b1);
         gcsr_pkg::IRQ_PP_HIGH: irq_pin_o = '{out: irq_active, oe: 1'b1};
         default:               irq_pin_o = '{out: 1'b0, oe: 1'b0};
      endcase
   end

   // R05 bus request style
   assign bus_request_out_o     = drive_low(bus_req_i, q.mode[gcsr_pkg::MODE_BUS_REQUEST_OUT]);
   assign soft_reset_o          = q.soft_rst;
   // R02 DMA enable out
   assign internal_dma_enable_o = q.mode[gcsr_pkg::MODE_DMA];
   // R04 oscillator power down
   assign osc_power_down_o      = q.mode[gcsr_pkg::MODE_OSC_PD];
   // R06 shaper bypass out
   assign shaper_bypass_o       = q.mode[gcsr_pkg::MODE_SHAPER];
   // R14 direction steers drivers
   assign port_pin_oe_o         = ~q.dir;
   // R15 driven output level
   assign port_pin_o            = q.dat;

   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (rst_i);

   soft_reset_seq_a: assert property (wr_soft |=> soft_reset_o ##1 (!soft_reset_o &&  // R01
      internal_dma_enable_o == 1'b0 && port_pin_oe_o == 3'h0))
      else $error("soft reset did not pulse once and restore fields");

   mode_reset_val_a: assert property (soft_reset_o |=> (osc_power_down_o && shaper_bypass_o  // R07
      && !internal_dma_enable_o && irq_pin_o.oe == 1'b0
      && bus_request_out_o.oe == bus_req_i && !bus_request_out_o.out))
      else $error("mode register not back at its reset value");

   mode_write_a: assert property ((wr_fire && q.w_en && q.aw_idx == gcsr_pkg::IDX_MODE  // R02
      && !q.soft_rst) |=> (internal_dma_enable_o == $past(q.w_data[7])
      && osc_power_down_o == $past(q.w_data[3]) && shaper_bypass_o == $past(q.w_data[1])))
      else $error("mode write did not reach the controls");

   irq_style_a: assert property ((irq_active && q.mode[5:4] == gcsr_pkg::IRQ_PP_HIGH)  // R03
      |-> (irq_pin_o.oe && irq_pin_o.out))
      else $error("push-pull high interrupt pin not driven high");

   bus_request_out_style_a: assert property ((bus_req_i && !q.mode[gcsr_pkg::MODE_BUS_REQUEST_OUT])  // R05
      |-> (bus_request_out_o.oe && !bus_request_out_o.out))
      else $error("open drain bus request not pulled low");

   gim_blocks_a: assert property (q.mode[gcsr_pkg::MODE_GIM]  // R08
      |-> (!irq_pin_o.oe || irq_pin_o.out == (q.mode[5:4] != gcsr_pkg::IRQ_PP_HIGH)))
      else $error("interrupt pin active under global mask");

   irq_pending_a: assert property ((!q.mode[gcsr_pkg::MODE_GIM] && q.mode[5:4] != 2'h2  // R09
      && |(q.irq_stat & ~q.irq_mask)) |-> (irq_pin_o.oe
      && irq_pin_o.out == (q.mode[5:4] == gcsr_pkg::IRQ_PP_HIGH)))
      else $error("pending unmasked event not signalled");

   buf_status_a: assert property ((rd_fire && rd_idx == gcsr_pkg::IDX_DMA_BUFFER_STATUS  // R10
      && internal_dma_enable_o) |=> s_axi_rdata_o[7:0] == {$past(buf_select_i[3]), 1'b0,
      $past(buf_select_i[2]), 1'b0, $past(buf_select_i[1]), 1'b0, $past(buf_select_i[0]), 1'b0})
      else $error("buffer status read does not match buffer selects");

   summary_read_a: assert property ((rd_fire && rd_idx == gcsr_pkg::IDX_GSTAT)  // R11 R12 R13 R16
      |=> (s_axi_rdata_o == {24'h000000, $past(src_pending_i)} && s_axi_rresp_o == 2'h0))
      else $error("global status read does not match sources");

   dir_read_a: assert property ((rd_fire && rd_idx == gcsr_pkg::IDX_DIR)  // R14
      |=> (s_axi_rdata_o[7:3] == 5'h1f && s_axi_rdata_o[2:0] == ~$past(port_pin_oe_o)))
      else $error("direction read wrong");

   port_write_a: assert property ((wr_fire && q.w_en && q.aw_idx == gcsr_pkg::IDX_DAT  // R15
      && !q.soft_rst) |=> port_pin_o == $past(q.w_data[2:0]))
      else $error("port data write not driven");

   write_cover_c: cover property (s_axi_bvalid_o && s_axi_bready_i);
   read_cover_c: cover property (rd_fire ##1 s_axi_rvalid_o ##[0:3] s_axi_rready_i);
   soft_cover_c: cover property (wr_soft ##2 !soft_reset_o);
   irq_cover_c: cover property (irq_active ##[1:8] !irq_active);

endmodule : gcsr_top
`default_nettype wire

// ---- verilog/gcsr_pkg.sv ----
// Constants, register map and carrier types of the global control and status register group.
// Notes on behaviour
// R01 - Writing one to soft reset resets everything; the code keeps the bus handshake and the pin synchronizers.
// R02 - Mode bit 7 enables the internal DMA.
// R03 - Interrupt pin style: 00 OD low, 01 PP low, 11 PP high.
// R04 - Oscillator power-down bit stops the internal oscillator.
// R05 - Bus request pin: 0 open drain, 1 push-pull.
// R06 - Shaper bypass bit: 0 shaper on, 1 bypassed.
// R07 - Global mode resets to 0b hexadecimal.
// R08 - Global interrupt mask forces interrupt pin inactive.
// R09 - Interrupt active while unmasked indication pending.
// R10 - Buffer status bits 7,5,3,1 show buffers.
// R11 - Status bit 7 flags port interrupt pending.
// R12 - Status bit 6 flags DMA interrupt pending.
// R13 - Status bits 5..0 flag channel status pending.
// R14 - Direction bit: 0 output, 1 input; reset ff.
// R15 - Port data reads pin level, writes output level.
// R16 - Summary follows sources; reading it clears nothing.
package gcsr_pkg;

   // Bus geometry: each register takes one aligned 32-bit word at four times its index.
   localparam int          ADDR_W        = 8;
   localparam int          IDX_W         = 6;
   localparam int          PORT_N        = 3;

   // Register indices.
   localparam logic [5:0]  IDX_CMD       = 6'h00;
   localparam logic [5:0]  IDX_MODE      = 6'h01;
   localparam logic [5:0]  IDX_DMA_BUFFER_STATUS      = 6'h02;
   localparam logic [5:0]  IDX_GSTAT     = 6'h03;
   localparam logic [5:0]  IDX_DIR       = 6'h05;
   localparam logic [5:0]  IDX_DAT       = 6'h07;
   localparam logic [5:0]  IDX_ISTAT     = 6'h08;
   localparam logic [5:0]  IDX_IMASK     = 6'h09;

   // Field positions.
   localparam int          CMD_SOFT_RST  = 0;
   localparam int          MODE_DMA      = 7;
   localparam int          MODE_IRQ_HI   = 5;
   localparam int          MODE_IRQ_LO   = 4;
   localparam int          MODE_OSC_PD   = 3;
   localparam int          MODE_BUS_REQUEST_OUT     = 2;
   localparam int          MODE_SHAPER   = 1;
   localparam int          MODE_GIM      = 0;

   // Interrupt pin style codes.
   localparam logic [1:0]  IRQ_OD_LOW    = 2'h0;
   localparam logic [1:0]  IRQ_PP_LOW    = 2'h1;
   localparam logic [1:0]  IRQ_PP_HIGH   = 2'h3;

   // Reset values.
   localparam logic [7:0]  MODE_RST      = 8'h0b;
   localparam logic [7:0]  DIR_RST       = 8'hff;
   localparam logic [2:0]  DAT_RST       = 3'h0;
   localparam logic [7:0]  ISTAT_RST     = 8'h00;
   localparam logic [7:0]  IMASK_RST     = 8'hff;

   // Answers.
   localparam logic [1:0]  RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RESP_SLVERR   = 2'h2;

   // Pending summary from the source status registers, bit 7 first.
   typedef struct packed {
      logic       port_irq_pending;
      logic       dma_irq_pending;
      logic [2:0] chan_a_pending;
      logic [2:0] chan_b_pending;
   } gcsr_src_t;

   // Buffer in use per DMA direction, zero for base address one.
   typedef struct packed {
      logic tx_b_buffer_select;
      logic rx_b_buffer_select;
      logic tx_a_buffer_select;
      logic rx_a_buffer_select;
   } gcsr_bufsel_t;

   // Drive of one pin: level and output enable.
   typedef struct packed {
      logic out;
      logic oe;
   } gcsr_pin_t;

   // All state of the register group.
   typedef struct packed {
      logic                aw_got;
      logic [IDX_W-1:0]    aw_idx;
      logic                w_got;
      logic [7:0]          w_data;
      logic                w_en;
      logic                bvalid;
      logic [1:0]          bresp;
      logic                rvalid;
      logic [7:0]          rdata;
      logic [1:0]          rresp;
      logic                soft_rst;
      logic [7:0]          mode;
      logic [PORT_N-1:0]   dir;
      logic [PORT_N-1:0]   dat;
      logic [PORT_N-1:0]   pin_s1;
      logic [PORT_N-1:0]   pin_s2;
      logic [7:0]          gsum_prev;
      logic [7:0]          irq_stat;
      logic [7:0]          irq_mask;
   } gcsr_state_t;

endpackage : gcsr_pkg

// ---- tb/gcsr_host_model.sv ----
// Behavioural AXI4-Lite host that issues one register access at a time.
`timescale 1ns/10ps
`default_nettype none
module gcsr_host_model (
   // Clock and pacing
   input  wire logic                        clk_sys_i,
   input  wire logic [3:0]                  stall_i,
   // Result, response code above the data
   output logic                             done_o,
   output logic [33:0]                      res_o,
   // Requests
   output logic                             awvalid_o,
   output logic                             wvalid_o,
   output logic                             arvalid_o,
   output logic [gcsr_pkg::ADDR_W-1:0]      addr_o,
   output logic [31:0]                      wdata_o,
   output logic                             bready_o,
   output logic                             rready_o,
   // Answers: awready, wready, bvalid, arready, rvalid
   input  wire logic [4:0]                  hs_i,
   input  wire logic [1:0]                  bresp_i,
   input  wire logic [1:0]                  rresp_i,
   input  wire logic [31:0]                 rdata_i
);
   initial begin
      {done_o, res_o, awvalid_o, wvalid_o, arvalid_o} = '0;
      {addr_o, wdata_o, bready_o, rready_o} = '0;
   end

   // Address and data go out together; each drops only at the edge its own ready is seen.
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_sys_i);
      awvalid_o <= wr;
      wvalid_o  <= wr;
      arvalid_o <= !wr;
      addr_o    <= a;
      wdata_o   <= d;
      forever begin
         @(posedge clk_sys_i);
         n++;
         if (hs_i[4]) awvalid_o <= 1'b0;
         if (hs_i[3]) wvalid_o <= 1'b0;
         if (hs_i[1]) arvalid_o <= 1'b0;
         if ((bready_o && hs_i[2]) || (rready_o && hs_i[0])) begin
            res_o <= wr ? {bresp_i, 32'h0} : {rresp_i, rdata_i};
            break;
         end
         // A slow host leaves the answer waiting; once raised, ready holds until taken.
         bready_o <= wr && n > stall_i;
         rready_o <= !wr && n > stall_i;
      end
      bready_o <= 1'b0;
      rready_o <= 1'b0;
      done_o   <= 1'b1;
      @(posedge clk_sys_i);
      done_o <= 1'b0;
   endtask : xfer
endmodule : gcsr_host_model
`default_nettype wire

// ---- tb/gcsr_top_test.sv ----
// Self-checking bench of the global control and status register group.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin error_cnt++; \
   $display("[ERR] %0t got %0h exp %0h", $time, (a), (e)); end end
module gcsr_top_test;
   logic                   clk_sys_i = 1'b0;
   logic                   rst_i = 1'b1;
   logic                   aw_v, aw_r, w_v, w_r, b_v, b_r, ar_v, ar_r, r_v, r_r;
   logic                   bus_request_out, srst, dma, osc_power_down, shp, done;
   logic [1:0]             b_s, r_s, resp_x;
   logic [2:0]             pin_ext, pin_i, pin_o, pin_oe;
   logic [3:0]             stall;
   logic [7:0]             addr, b8;
   logic [15:0]            lfsr_q;
   logic [31:0]            w_d, r_d;
   logic [33:0]            res, e_m;
   logic [33:0]            exp_q[$];
   gcsr_pkg::gcsr_src_t    src;
   gcsr_pkg::gcsr_bufsel_t bsel;
   gcsr_pkg::gcsr_pin_t    irq, brq;
   int                     error_cnt, checks_done, cyc, srst_cnt, i;
   logic [1:0]             sty[4] = '{2'h0, 2'h1, 2'h3, 2'h2};
   logic [1:0]             pe[4] = '{2'h1, 2'h1, 2'h3, 2'h0};

   always #5 clk_sys_i = ~clk_sys_i;
   // Port pins carry no pull, so a released pin shows the random outside level.
   assign pin_i = (pin_oe & pin_o) | (~pin_oe & pin_ext);

   gcsr_top gcsr_top_i (
      .clk_sys_i(clk_sys_i), .rst_i(rst_i),
      .s_axi_awvalid_i(aw_v), .s_axi_awready_o(aw_r), .s_axi_awaddr_i(addr),
      .s_axi_wvalid_i(w_v), .s_axi_wready_o(w_r), .s_axi_wdata_i(w_d), .s_axi_wstrb_i(4'hf),
      .s_axi_bvalid_o(b_v), .s_axi_bready_i(b_r), .s_axi_bresp_o(b_s),
      .s_axi_arvalid_i(ar_v), .s_axi_arready_o(ar_r), .s_axi_araddr_i(addr),
      .s_axi_rvalid_o(r_v), .s_axi_rready_i(r_r), .s_axi_rdata_o(r_d), .s_axi_rresp_o(r_s),
      .src_pending_i(src), .buf_select_i(bsel), .bus_req_i(bus_request_out),
      .soft_reset_o(srst), .internal_dma_enable_o(dma), .osc_power_down_o(osc_power_down),
      .shaper_bypass_o(shp), .irq_pin_o(irq), .bus_request_out_o(brq),
      .port_pin_i(pin_i), .port_pin_o(pin_o), .port_pin_oe_o(pin_oe)
   );
   gcsr_host_model gcsr_host_model_i (
      .clk_sys_i(clk_sys_i), .stall_i(stall), .done_o(done), .res_o(res),
      .awvalid_o(aw_v), .wvalid_o(w_v), .arvalid_o(ar_v), .addr_o(addr), .wdata_o(w_d),
      .bready_o(b_r), .rready_o(r_r), .hs_i({aw_r, w_r, b_v, ar_r, r_v}),
      .bresp_i(b_s), .rresp_i(r_s), .rdata_i(r_d)
   );

   function automatic logic [15:0] lfsr_next(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction : lfsr_next

   task automatic close_out();
      if (error_cnt == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : close_out

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      exp_q.push_back({resp_x, 32'h0});
      gcsr_host_model_i.xfer(1'b1, a, {24'h0, d});
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back({resp_x, 24'h0, e});
      gcsr_host_model_i.xfer(1'b0, a, 32'h0);
   endtask : rd

   // Each finished access is judged against the oldest noted expectation.
   always @(posedge clk_sys_i) begin
      cyc++;
      if (srst === 1'b1)
         srst_cnt++;
      if (done === 1'b1) begin
         e_m = exp_q.pop_front();
         `CHK(res, e_m)
      end
      if (cyc > 5000) begin
         error_cnt++;
         close_out();
      end
   end

   initial begin
      src = '0;
      bsel = '0;
      bus_request_out = 1'b0;
      pin_ext = 3'h0;
      stall = 4'h0;
      resp_x = gcsr_pkg::RESP_OKAY;
      lfsr_q = 16'h3364;
      repeat (10) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      rd(8'h04, gcsr_pkg::MODE_RST);
      rd(8'h14, 8'hff);
      `CHK({osc_power_down, shp, dma}, 3'b110)
      wr(8'h24, 8'h01);
      wr(8'h04, 8'h30);
      @(posedge clk_sys_i);
      src <= 8'h01;
      repeat (3) @(posedge clk_sys_i);
      #1;
      `CHK(irq, 2'b01)
      rd(8'h20, 8'h01);
      wr(8'h24, 8'h00);
      @(posedge clk_sys_i);
      src <= 8'h02;
      for (i = 0; i < 4; i++) begin
         wr(8'h04, {2'h0, sty[i], 4'h0});
         #1;
         `CHK({irq.out & irq.oe, irq.oe}, pe[i])
      end
      wr(8'h04, 8'h31);
      #1;
      `CHK(irq, 2'b01)
      @(posedge clk_sys_i);
      src <= 8'h06;
      wr(8'h04, 8'h30);
      #1;
      `CHK(irq, 2'b11)
      rd(8'h20, 8'h06);
      #1;
      `CHK(irq, 2'b01)
      for (i = 0; i < 4; i++) begin
         @(posedge clk_sys_i);
         bus_request_out <= i[0];
         wr(8'h04, {5'h0, i[1], 2'h0});
         #1;
         `CHK(brq, i[1] ? {~i[0], 1'b1} : {1'b0, i[0]})
      end
      `CHK({osc_power_down, shp}, 2'b00)
      for (i = 0; i < 2; i++) begin
         lfsr_q = lfsr_next(lfsr_q);
         @(posedge clk_sys_i);
         bsel <= lfsr_q[3:0];
         wr(8'h04, {i[0], 7'h0});
         wr(8'h08, 8'hff);
         #1;
         `CHK(dma, i[0])
         b8 = {lfsr_q[3], 1'b0, lfsr_q[2], 1'b0, lfsr_q[1], 1'b0, lfsr_q[0], 1'b0};
         rd(8'h08, i[0] ? b8 : 8'h00);
      end
      for (i = 0; i < 4; i++) begin
         lfsr_q = lfsr_next(lfsr_q);
         @(posedge clk_sys_i);
         src <= lfsr_q[7:0];
         rd(8'h0c, lfsr_q[7:0]);
         rd(8'h0c, lfsr_q[7:0]);
      end
      wr(8'h14, 8'h05);
      #1;
      `CHK(pin_oe, 3'b010)
      lfsr_q = lfsr_next(lfsr_q);
      @(posedge clk_sys_i);
      pin_ext <= lfsr_q[2:0];
      for (i = 1; i >= 0; i--) begin
         wr(8'h1c, {6'h0, i[0], 1'b0});
         #1;
         `CHK(pin_i[1], i[0])
         rd(8'h1c, {5'h0, lfsr_q[2], i[0], lfsr_q[0]});
      end
      rd(8'h14, 8'hfd);
      // Unmapped places answer with an error, here to a slow host.
      stall <= 4'h3;
      resp_x = gcsr_pkg::RESP_SLVERR;
      rd(8'h10, 8'h00);
      wr(8'h18, 8'hff);
      resp_x = gcsr_pkg::RESP_OKAY;
      stall <= 4'h0;
      wr(8'h04, 8'h8e);
      `CHK({osc_power_down, shp, dma}, 3'b111)
      wr(8'h00, 8'h00);
      rd(8'h04, 8'h8e);
      wr(8'h00, 8'h01);
      repeat (2) @(posedge clk_sys_i);
      `CHK(srst_cnt, 1)
      rd(8'h04, gcsr_pkg::MODE_RST);
      rd(8'h14, gcsr_pkg::DIR_RST);
      rd(8'h00, 8'h00);
      close_out();
   end
endmodule : gcsr_top_test
`default_nettype wire
